// ### hw/twsp_pkg.sv
// Package of constants and types for the three-wire serial port
// Contract
// - Control register is read/write; all non-reserved bits reset to zero.
// - module_enable low disables port and clears busy, read-full, overrun flags.
// - Disabled: master holds clock idle, output known; slave output released.
// - Control bit 1 selects role: 0 slave, 1 master.
// - Control bit 2 selects 8 or 16 bit words; change only when idle.
// - Slave loopback bit 3 echoes input when no valid data; idle writes only.
// - Transmit data stays valid from data write until its transfer ends.
// - Overrun enable bit 4 raises interrupt on overrun; master mode only.
// - Read enable bit 5 requests interrupt when read buffer becomes full.
// - Write enable bit 6 requests interrupt when busy clears.
// - Clock mode bit 7: 0 launch falling sample rising; 1 the reverse.
// - Clock idle bit 8 sets master clock idle level; change only when idle.
// - Master divides system clock by two times divider field plus one.
// - Master sets busy on data register write.
// - Slave sets busy on first leading clock edge with select, or write.
// - Busy clears only when transfer done and read buffer can accept.
// - Read-full sets when shifter loads an empty read buffer.
// - Data read clears read-full unless a new word waits; then reload.
// - Master overrun sets when transfer starts with buffer and shifter full.
// - Overrun clears only by writing one; no other status bit changes.
// - Shift MSB first, one bit per clock; 8-bit mode uses lower byte.
// - Master data write starts 8 or 16 clocks, then clock returns idle.
package twsp_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [11:0] ADDR_DATA   = 12'h000;
   localparam logic [11:0] ADDR_CTRL   = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_EN    = 0;
   localparam int CTL_ROLE  = 1;
   localparam int CTL_WLEN  = 2;
   localparam int CTL_ECHO  = 3;
   localparam int CTL_EIO   = 4;
   localparam int CTL_EIR   = 5;
   localparam int CTL_EIW   = 6;
   localparam int CTL_SCM   = 7;
   localparam int CTL_IDLE  = 8;
   localparam int CTL_DIV_L = 9;
   localparam int ST_BSY    = 0;
   localparam int ST_RBF    = 1;
   localparam int ST_OVR    = 2;
   localparam logic [4:0] BITS_8  = 5'h08;
   localparam logic [4:0] BITS_16 = 5'h10;

   // Decoded control word
   typedef struct packed {
      logic [6:0] divider;
      logic       idle_level;
      logic       edge_mode;
      logic       transfer_done_irq_enable;
      logic       read_full_irq_enable;
      logic       overrun_irq_enable;
      logic       echo;
      logic       wlen16;
      logic       master;
      logic       enable;
   } twsp_ctrl_type;

   // Serial pin group toward the link
   typedef struct packed {
      logic sck_o;
      logic sck_oe_n;
      logic mosi_o;
      logic mosi_oe_n;
      logic miso_o;
      logic miso_oe_n;
   } twsp_pins_type;

   // Transfer engine states, Gray along the usual path except the trail-to-idle step
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEAD = 2'b01,
      ST_TRAIL = 2'b11
   } twsp_state_type;
endpackage

// ### hw/twsp_clkdiv.sv
// Master shift clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none
module twsp_clkdiv (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       run,
   input  wire logic [6:0] divider,
   output logic            tick
);
   logic [6:0] cnt_q;

   // ----------------------------------------
   // Half period of divider plus one system clocks
   // ----------------------------------------
   // divide by divider plus one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 7'h00;
      end else if (!run || cnt_q == divider) begin
         cnt_q <= 7'h00;
      end else begin
         cnt_q <= cnt_q + 7'h01;
      end
   end

   assign tick = run && (cnt_q == divider);
endmodule
`default_nettype wire

// ### hw/twsp_core.sv
// Three-wire serial port control, status and shifter with APB slave
`timescale 1ns/1ps
`default_nettype none
module twsp_core (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic      [31:0]            prdata,
   output logic                        pready,
   output logic                        pslverr,
   input  wire logic                   sck_i,
   input  wire logic                   mosi_i,
   input  wire logic                   miso_i,
   input  wire logic                   slave_chip_select_n,
   output twsp_pkg::twsp_pins_type     pins,
   output logic                        irq
);
   twsp_pkg::twsp_ctrl_type  ctrl;
   twsp_pkg::twsp_state_type state_q;
   logic [15:0] ctrl_q;
   logic [15:0] shift_q;
   logic [15:0] rbuf_q;
   logic [15:0] rdata_d;
   logic [4:0]  cnt_q;
   logic        bsy_q, rbf_q, ovr_q, held_q, valid_q, sck_q, out_q;
   logic        sck_s_q, done_q;
   logic        wr, rd, wr_data, rd_data, wr_ctrl, wr_stat;
   logic        tick, lead_m, trail_m, lead_s, trail_s, lead, trail;
   logic        launch, sample, sin, last, finish, start, s_sel;
   logic [4:0]  nbits;

   assign ctrl = twsp_pkg::twsp_ctrl_type'(ctrl_q);

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   // Address match helper
   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      hit = (a == r);
   endfunction

   assign pready  = 1'b1;
   assign wr      = psel && penable && pwrite;
   assign rd      = psel && penable && !pwrite;
   assign wr_data = wr && hit(paddr, twsp_pkg::ADDR_DATA);
   assign wr_ctrl = wr && hit(paddr, twsp_pkg::ADDR_CTRL);
   assign wr_stat = wr && hit(paddr, twsp_pkg::ADDR_STATUS);
   assign rd_data = rd && hit(paddr, twsp_pkg::ADDR_DATA);
   assign pslverr = psel && penable && !hit(paddr, twsp_pkg::ADDR_DATA)
                    && !hit(paddr, twsp_pkg::ADDR_CTRL) && !hit(paddr, twsp_pkg::ADDR_STATUS);

   // Read mux
   always_comb begin
      rdata_d = 16'h0000;
      if (hit(paddr, twsp_pkg::ADDR_DATA)) begin
         rdata_d = rbuf_q;
      end else if (hit(paddr, twsp_pkg::ADDR_CTRL)) begin
         rdata_d = ctrl_q;
      end else if (hit(paddr, twsp_pkg::ADDR_STATUS)) begin
         rdata_d = {13'h0, ovr_q, rbf_q, bsy_q};
      end
   end
   assign prdata = {16'h0000, rdata_d};

   // ----------------------------------------
   // Control register
   // ----------------------------------------
   // zero at reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= twsp_pkg::CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[15:0];
      end
   end

   // ----------------------------------------
   // Shift clock generation and edge detection
   // ----------------------------------------
   twsp_clkdiv u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .run     (state_q != twsp_pkg::ST_IDLE && ctrl.master),
      .divider (ctrl.divider),
      .tick    (tick)
   );

   // Slave clock edge history (inputs are synchronous)
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_s_q <= 1'b0;
      end else begin
         sck_s_q <= sck_i;
      end
   end

   // Leading edge leaves idle level, trailing edge returns to it
   assign lead_m  = tick && state_q == twsp_pkg::ST_LEAD;
   assign trail_m = tick && state_q == twsp_pkg::ST_TRAIL;
   assign lead_s  = s_sel && (sck_i != sck_s_q) && (sck_i != ctrl.idle_level);
   assign trail_s = s_sel && (sck_i != sck_s_q) && (sck_i == ctrl.idle_level);
   assign s_sel   = ctrl.enable && !ctrl.master && !slave_chip_select_n;
   assign lead    = ctrl.master ? lead_m : lead_s;
   assign trail   = ctrl.master ? trail_m : trail_s;

   // edge mode picks launch and sample edges
   assign launch = (ctrl.edge_mode ^ ctrl.idle_level) ? lead : trail;
   assign sample = (ctrl.edge_mode ^ ctrl.idle_level) ? trail : lead;
   assign nbits  = ctrl.wlen16 ? twsp_pkg::BITS_16 : twsp_pkg::BITS_8;
   assign last   = (cnt_q == nbits - 5'h01);
   assign sin    = ctrl.master ? miso_i : mosi_i;
   assign start  = ctrl.master ? (wr_data && ctrl.enable) :
                   (lead_s && !bsy_q) || (wr_data && ctrl.enable);
   assign finish = sample && last;

   // ----------------------------------------
   // Transfer state machine
   // ----------------------------------------
   // idle level, burst of 8 or 16 clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= twsp_pkg::ST_IDLE;
         sck_q   <= 1'b0;
      end else if (!ctrl.enable) begin
         state_q <= twsp_pkg::ST_IDLE;
         sck_q   <= ctrl.idle_level;
      end else begin
         case (state_q)
            twsp_pkg::ST_IDLE: begin
               sck_q <= ctrl.idle_level;
               if (ctrl.master && wr_data) begin
                  state_q <= twsp_pkg::ST_LEAD;
               end
            end
            twsp_pkg::ST_LEAD: begin
               if (lead_m) begin
                  sck_q   <= !ctrl.idle_level;
                  state_q <= twsp_pkg::ST_TRAIL;
               end
            end
            twsp_pkg::ST_TRAIL: begin
               if (trail_m) begin
                  // Ends at the last sample, or just after it when sampling leads
                  sck_q   <= ctrl.idle_level;
                  state_q <= (sample ? last : (cnt_q == 5'h00)) ? twsp_pkg::ST_IDLE
                                                                : twsp_pkg::ST_LEAD;
               end
            end
            default: begin
               state_q <= twsp_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Bit counter and shifter
   // ----------------------------------------
   // word length, MSB first, one bit per clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 5'h00;
      end else if (!ctrl.enable || (!ctrl.master && slave_chip_select_n) || finish) begin
         cnt_q <= 5'h00;
      end else if (sample) begin
         cnt_q <= cnt_q + 5'h01;
      end
   end

   // Output bit launch; first bit is presented before the first edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_q <= 16'h0000;
      end else if (wr_data) begin
         shift_q <= pwdata[15:0];
      end else if (sample) begin
         if (ctrl.wlen16) begin
            shift_q <= {shift_q[14:0], sin};
         end else begin
            shift_q <= {shift_q[15:8], shift_q[6:0], sin};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_q <= 1'b0;
      end else if (wr_data) begin
         out_q <= ctrl.wlen16 ? pwdata[15] : pwdata[7];   // Shifter loads on this edge
      end else if (!ctrl.master && ctrl.echo && !valid_q && sample) begin
         out_q <= sin;
      end else if (launch || (state_q == twsp_pkg::ST_IDLE && !bsy_q)) begin
         out_q <= ctrl.wlen16 ? shift_q[15] : shift_q[7];
      end
   end

   // data valid from write until transfer end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         valid_q <= 1'b0;
      end else if (!ctrl.enable || done_q) begin
         valid_q <= 1'b0;
      end else if (wr_data) begin
         valid_q <= 1'b1;
      end
   end

   // Word completion pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else begin
         done_q <= finish;
      end
   end

   // ----------------------------------------
   // Read buffer and status flags
   // ----------------------------------------
   // load empty buffer, reload on read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rbuf_q <= 16'h0000;
         rbf_q  <= 1'b0;
         held_q <= 1'b0;
      end else if (!ctrl.enable) begin
         rbf_q  <= 1'b0;
         held_q <= 1'b0;
      end else if (done_q && (!rbf_q || rd_data)) begin
         rbuf_q[7:0] <= shift_q[7:0];
         if (ctrl.wlen16) begin
            rbuf_q[15:8] <= shift_q[15:8];
         end
         rbf_q <= 1'b1;
      end else if (done_q) begin
         held_q <= 1'b1;
      end else if (rd_data && held_q) begin
         rbuf_q[7:0] <= shift_q[7:0];
         if (ctrl.wlen16) begin
            rbuf_q[15:8] <= shift_q[15:8];
         end
         held_q <= 1'b0;
      end else if (rd_data) begin
         rbf_q <= 1'b0;
      end
   end

   // disable clears; busy set on start, cleared on accept
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bsy_q <= 1'b0;
      end else if (!ctrl.enable) begin
         bsy_q <= 1'b0;
      end else if (start) begin
         bsy_q <= 1'b1;
      end else if ((done_q && (!rbf_q || rd_data)) || (held_q && rd_data)) begin
         bsy_q <= 1'b0;
      end
   end

   // overrun sticky, write one clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovr_q <= 1'b0;
      end else if (!ctrl.enable) begin
         ovr_q <= 1'b0;
      end else if (ctrl.master && wr_data && rbf_q && held_q) begin
         ovr_q <= 1'b1;
      end else if (wr_stat && pwdata[twsp_pkg::ST_OVR]) begin
         ovr_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pins and interrupt
   // ----------------------------------------
   // pin directions by role and enable
   always_comb begin
      pins.sck_o     = sck_q;
      pins.sck_oe_n  = !ctrl.master;
      pins.mosi_o    = out_q;
      pins.mosi_oe_n = !ctrl.master;
      pins.miso_o    = out_q;
      pins.miso_oe_n = ctrl.master || !s_sel;
   end

   assign irq = (ctrl.overrun_irq_enable && ovr_q) || (ctrl.read_full_irq_enable && rbf_q) || (ctrl.transfer_done_irq_enable && ctrl.enable && !bsy_q);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_disable_clears;
      @(posedge pclk) disable iff (!presetn)
      !ctrl.enable |=> !bsy_q && !rbf_q && !ovr_q;
   endproperty
   a_disable_clears: assert property (p_disable_clears) else $error("flags not cleared");

   property p_master_busy;
      @(posedge pclk) disable iff (!presetn)
      ctrl.enable && ctrl.master && wr_data |=> bsy_q;
   endproperty
   a_master_busy: assert property (p_master_busy) else $error("busy not set");

   property p_ovr_sticky;
      @(posedge pclk) disable iff (!presetn)
      ovr_q && ctrl.enable && !(wr_stat && pwdata[twsp_pkg::ST_OVR]) |=> ovr_q;
   endproperty
   a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun lost");

   property p_rbf_set;
      @(posedge pclk) disable iff (!presetn)
      done_q && !rbf_q && ctrl.enable |=> rbf_q;
   endproperty
   a_rbf_set: assert property (p_rbf_set) else $error("read full not set");

   property p_held_keeps_busy;
      @(posedge pclk) disable iff (!presetn)
      held_q && ctrl.enable && !rd_data |=> bsy_q;
   endproperty
   a_held_keeps_busy: assert property (p_held_keeps_busy) else $error("busy dropped");

   property p_read_reload;
      @(posedge pclk) disable iff (!presetn)
      rd_data && held_q && ctrl.enable && !done_q |=> rbf_q && !held_q;
   endproperty
   a_read_reload: assert property (p_read_reload) else $error("reload failed");

   property p_idle_clock;
      @(posedge pclk) disable iff (!presetn)
      ctrl.master && $stable(ctrl_q) && !ctrl.enable |=> pins.sck_o == $past(ctrl.idle_level);
   endproperty
   a_idle_clock: assert property (p_idle_clock) else $error("clock not idle");

   property p_slave_release;
      @(posedge pclk) disable iff (!presetn)
      !ctrl.master && !ctrl.enable |-> pins.miso_oe_n && pins.sck_oe_n && pins.mosi_oe_n;
   endproperty
   a_slave_release: assert property (p_slave_release) else $error("slave drives");

   property p_irq_read;
      @(posedge pclk) disable iff (!presetn)
      ctrl.read_full_irq_enable && rbf_q |-> irq;
   endproperty
   a_irq_read: assert property (p_irq_read) else $error("no read irq");

   property p_role_dir;
      @(posedge pclk) disable iff (!presetn)
      ctrl.master |-> !pins.sck_oe_n && pins.miso_oe_n;
   endproperty
   a_role_dir: assert property (p_role_dir) else $error("wrong role");
endmodule
`default_nettype wire

// ### tb/twsp_slave_model.sv
// Behavioural far-side peer on the three-wire link
`timescale 1ns/1ps
`default_nettype none
module twsp_slave_model (
   input  wire logic        pclk,
   input  wire logic        active,
   input  wire logic        sck,
   input  wire logic        mosi,
   input  wire logic        wlen16,
   input  wire logic        edge_mode,
   input  wire logic [15:0] tx_word,
   output logic             miso,
   output logic      [15:0] rx_word
);
   logic [15:0] sr;
   logic        sck_q;
   logic        act_q;
   logic        seen;

   // sample and launch
   // Load at frame start, sample on one edge, launch on the other
   always @(posedge pclk) begin
      sck_q <= sck;
      act_q <= active;
      if (active && !act_q) begin
         sr <= wlen16 ? tx_word : {tx_word[7:0], 8'h00};
         seen <= 1'b0;
         rx_word <= 16'h0000;
      end else if (active && sck != sck_q) begin
         if (sck ^ edge_mode) begin
            rx_word <= {rx_word[14:0], mosi};
            seen <= 1'b1;
         end else if (seen) begin
            sr <= {sr[14:0], ~sr[15]};   // A leading launch edge before any sample keeps MSB
         end
      end
   end

   // Released line shows the inverse of the last bit
   assign miso = active ? sr[15] : ~sr[15];
endmodule
`default_nettype wire

// ### tb/tb.sv
// Self-checking testbench for the three-wire serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
   typedef struct packed {
      logic [32:0] v;
      logic [32:0] m;
   } twsp_exp_type;
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic                    sck_i, mosi_i, miso_i, cs_n, act, sck_q, wl, em, idl;
   logic [11:0]             paddr;
   logic [31:0]             pwdata, prdata, rq;
   logic [15:0]             mtx, rxw, c, tx, msk;
   twsp_pkg::twsp_pins_type pins;
   twsp_exp_type            exp_q[$];
   twsp_exp_type            e;
   int                      fail_count, total_checks, pulses, cyc, period, seed, i, dv;

   twsp_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sck_i(sck_i), .mosi_i(mosi_i), .miso_i(miso_i),
      .slave_chip_select_n(cs_n), .pins(pins), .irq(irq));
   twsp_slave_model peer (.pclk(pclk), .active(act), .sck(pins.sck_o), .mosi(pins.mosi_o),
      .wlen16(wl), .edge_mode(em), .tx_word(mtx), .miso(miso_i), .rx_word(rxw));

   // 50 MHz clock
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [32:0] s, input logic [32:0] x, input string n);
      total_checks++;
      if (s !== x) begin
         fail_count++;
         $display("mismatch %s exp %h seen %h", n, x, s);
      end
   endtask

   // One APB transfer; reads queue their expectation for the monitor
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] v, input logic [32:0] m, output logic [31:0] q);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back({v, m});
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      apb(1'b1, a, {16'h0000, d}, 33'h0, 33'h0, rq);
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] v, input logic [15:0] m);
      apb(1'b0, a, 32'h0000_0000, {17'h0_0000, v}, {17'h0_0000, m}, rq);
   endtask

   task automatic wait_pulses(input int n);
      int k;
      k = 0;
      while (pulses < n && k < 3000) begin
         @(posedge pclk);
         k++;
      end
      if (pulses < n) fail_count++;
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      do begin
         apb(1'b0, twsp_pkg::ADDR_STATUS, 32'h0000_0000, 33'h0, 33'h0, rq);
         k++;
      end while (rq[0] !== 1'b0 && k < 100);
      if (rq[0] !== 1'b0) fail_count++;
   endtask

   // Master frame with the peer taking part
   task automatic mxfer(input logic [15:0] d, input int n);
      @(posedge pclk);
      act <= 1'b1;
      pulses = 0;
      wr(twsp_pkg::ADDR_DATA, d);
      wait_pulses(n);
      repeat (12) @(posedge pclk);   // A trailing last sample still needs the peer
      act <= 1'b0;
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Monitors
   // ----------------------------------------
   // Read results against queued notes; shift clock pulses and period
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         check({pslverr, prdata} & e.m, e.v, "apb read");
      end
      cyc = cyc + 1;
      if (pins.sck_o === 1'b1 && sck_q === 1'b0) begin
         pulses++;
         period = cyc;
         cyc = 0;
      end
      sck_q = pins.sck_o;
   end

   // Watchdog
   initial begin
      #600_000;
      fail_count++;
      report_and_stop();
   end

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {psel, penable, pwrite, sck_i, mosi_i, act, presetn, sck_q, wl, em} = 10'h000;
      cs_n = 1'b1;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      mtx = 16'h0000;
      {fail_count, total_checks, pulses, cyc, period} = {5{32'h0000_0000}};
      seed = $urandom(55);
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      check({pins.sck_oe_n, pins.mosi_oe_n, pins.miso_oe_n, irq}, 4'hE, "reset pins");
      rd(twsp_pkg::ADDR_STATUS, 16'h0000, 16'h0007);
      rd(twsp_pkg::ADDR_CTRL, 16'h0000, 16'hFFFF);
      c = 16'($urandom) & 16'hFFFE;
      wr(twsp_pkg::ADDR_CTRL, c);
      rd(twsp_pkg::ADDR_CTRL, c, 16'hFFFF);
      apb(1'b0, 12'h00C, 32'h0000_0000, 33'h1_0000_0000, 33'h1_0000_0000, rq);
      // master frames over all lengths and edges
      for (i = 0; i < 4; i++) begin
         wl = i[0];
         em = i[1];
         idl = i[0] ^ i[1];
         dv = 1 + int'($urandom % 3);
         msk = wl ? 16'hFFFF : 16'h00FF;
         c = {dv[6:0], idl, em, 3'b010, 1'b0, wl, 1'b1, 1'b0};
         wr(twsp_pkg::ADDR_CTRL, c);
         repeat (2) @(posedge pclk);
         check({pins.sck_o, pins.sck_oe_n, pins.miso_oe_n}, {idl, 2'b01}, "idle pins");
         wr(twsp_pkg::ADDR_CTRL, c | 16'h0001);
         mtx <= 16'($urandom);
         tx = 16'($urandom);
         mxfer(tx, wl ? 16 : 8);
         wait_idle();
         check(pulses, wl ? 16 : 8, "pulses");
         check(period, 2 * (dv + 1), "period");
         check(rxw & msk, tx & msk, "peer rx");
         check(irq, 1'b1, "irq full");
         rd(twsp_pkg::ADDR_STATUS, 16'h0002, 16'h0007);
         rd(twsp_pkg::ADDR_DATA, mtx & msk, msk);
         rd(twsp_pkg::ADDR_STATUS, 16'h0000, 16'h0007);
         @(posedge pclk);
         check(irq, 1'b0, "irq clear");
         wr(twsp_pkg::ADDR_CTRL, c);
      end
      wl = 1'b0;
      em = 1'b0;
      wr(twsp_pkg::ADDR_CTRL, 16'h0212);
      wr(twsp_pkg::ADDR_CTRL, 16'h0213);
      mxfer(16'h00A5, 8);
      wait_idle();
      mxfer(16'h005A, 8);
      repeat (6) @(posedge pclk);
      rd(twsp_pkg::ADDR_STATUS, 16'h0003, 16'h0007);
      wr(twsp_pkg::ADDR_DATA, 16'h00C3);
      rd(twsp_pkg::ADDR_STATUS, 16'h0006, 16'h0006);
      check(irq, 1'b1, "irq overrun");
      wr(twsp_pkg::ADDR_STATUS, 16'h0000);
      rd(twsp_pkg::ADDR_STATUS, 16'h0004, 16'h0004);
      wr(twsp_pkg::ADDR_STATUS, 16'h0004);
      rd(twsp_pkg::ADDR_STATUS, 16'h0002, 16'h0006);
      rd(twsp_pkg::ADDR_DATA, 16'h0000, 16'h0000);
      rd(twsp_pkg::ADDR_STATUS, 16'h0002, 16'h0002);
      wr(twsp_pkg::ADDR_CTRL, 16'h0212);
      rd(twsp_pkg::ADDR_STATUS, 16'h0000, 16'h0007);
      wr(twsp_pkg::ADDR_CTRL, 16'h0000);
      wr(twsp_pkg::ADDR_CTRL, 16'h0001);
      cs_n <= 1'b0;
      tx = 16'($urandom) & 16'h00FF;
      for (i = 7; i >= 0; i--) begin
         @(posedge pclk);
         mosi_i <= tx[i];
         repeat (3) @(posedge pclk);
         sck_i <= 1'b1;
         repeat (3) @(posedge pclk);
         if (i == 7) rd(twsp_pkg::ADDR_STATUS, 16'h0001, 16'h0001);
         @(posedge pclk);
         sck_i <= 1'b0;
      end
      check(pins.miso_oe_n, 1'b0, "slave drive");
      wait_idle();
      rd(twsp_pkg::ADDR_DATA, tx, 16'h00FF);
      cs_n <= 1'b1;
      wr(twsp_pkg::ADDR_CTRL, 16'h0000);
      wr(twsp_pkg::ADDR_CTRL, 16'h0242);
      wr(twsp_pkg::ADDR_CTRL, 16'h0243);
      repeat (2) @(posedge pclk);
      check(irq, 1'b1, "irq done");
      report_and_stop();
   end
endmodule
`default_nettype wire
